// >>> src/cabx_pkg.sv
// constants, operation codes and flag layout for the alu and branch execution block
// assumes a separate decoder turns fetched words into one cabx_op_t per instruction
package cabx_pkg;

  // bit positions inside the status flags register
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // datapath widths
  localparam int unsigned PC_WIDTH = 22;
  localparam int unsigned PTR_WIDTH = 16;
  localparam int unsigned OFFSET_WIDTH = 7;
  localparam int unsigned IMM_WORD_WIDTH = 6;
  // program counter at or below this width calls in the short form
  localparam int unsigned SHORT_CALL_PC_WIDTH = 16;

  // cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // program counter steps
  localparam int unsigned PC_STEP_NEXT = 1;
  localparam int unsigned PC_STEP_SKIP_ONE = 2;
  localparam int unsigned PC_STEP_SKIP_TWO = 3;

  typedef enum logic [4:0] {
    OP_ADD_IMMEDIATE_TO_WORD,
    OP_SUBTRACT_IMMEDIATE_FROM_WORD,
    OP_AND_WITH_IMMEDIATE,
    OP_LOGICAL_OR_WITH_IMMEDIATE,
    OP_SET_BITS_IN_REGISTER,
    OP_CLEAR_BITS_IN_REGISTER,
    OP_TEST_ZERO_OR_MINUS,
    OP_MULTIPLY_UNSIGNED,
    OP_MULTIPLY_SIGNED,
    OP_MULTIPLY_SIGNED_BY_UNSIGNED,
    OP_FRACTIONAL_MULTIPLY_UNSIGNED,
    OP_FRACTIONAL_MULTIPLY_SIGNED,
    OP_FRACTIONAL_MULTIPLY_MIXED,
    OP_INDIRECT_JUMP,
    OP_INDIRECT_CALL,
    OP_COMPARE_SKIP_IF_EQUAL,
    OP_SKIP_IF_REG_BIT_CLEAR,
    OP_SKIP_IF_REG_BIT_SET,
    OP_SKIP_IF_IO_BIT_CLEAR,
    OP_SKIP_IF_IO_BIT_SET,
    OP_BRANCH_ON_FLAG_SET,
    OP_BRANCH_ON_FLAG_CLEAR,
    OP_BRANCH_GREATER_EQUAL_SIGNED,
    OP_BRANCH_LESS_SIGNED,
    OP_BRANCH_SAME_OR_HIGHER,
    OP_BRANCH_LOWER_UNSIGNED,
    OP_BRANCH_HALF_CARRY_SET,
    OP_BRANCH_HALF_CARRY_CLEAR,
    OP_BRANCH_TRANSFER_BIT_SET,
    OP_BRANCH_TRANSFER_BIT_CLEAR
  } cabx_op_t;

  typedef enum logic [1:0] {
    LOGIC_AND,
    LOGIC_OR,
    LOGIC_AND_NOT
  } cabx_logic_t;

  typedef enum {
    ST_IDLE,
    ST_RUN
  } cabx_state_t;

endpackage

// >>> src/cabx_logic.sv
// byte logic unit: and, or, and-with-complement of an 8-bit operand
// purely combinational; the caller registers result and flags
`timescale 1ns/100ps
`default_nettype none
module cabx_logic
  import cabx_pkg::*;
(
  input wire logic [7:0] a,
  input wire logic [7:0] k,
  input wire cabx_pkg::cabx_logic_t mode,
  output logic [7:0] res,
  output logic zero,
  output logic neg
);

  // one mux over the three bitwise forms
  always_comb
  begin
    case (mode)
      LOGIC_AND: res = a & k;
      LOGIC_OR: res = a | k;
      LOGIC_AND_NOT: res = a & ~k;
      default: res = a;
    endcase
    zero = (res == 8'h00);
    neg = res[7];
  end

endmodule // cabx_logic
`default_nettype wire

// >>> src/cabx_mul.sv
// 8x8 multiplier with per-operand signedness and an optional fractional shift
// purely combinational; the caller spends the second cycle around it
`timescale 1ns/100ps
`default_nettype none
module cabx_mul (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic a_signed,
  input wire logic b_signed,
  input wire logic frac,
  output logic [15:0] prod,
  output logic carry,
  output logic zero
);

  logic signed [8:0] ax;
  logic signed [8:0] bx;
  logic signed [17:0] full;

  // extend each operand by one bit so one signed multiplier covers all mixes
  always_comb
  begin
    ax = $signed({a_signed & a[7], a});
    bx = $signed({b_signed & b[7], b});
    full = ax * bx;
    // carry is the product's top bit before any fractional shift
    carry = full[15];
    prod = frac ? {full[14:0], 1'b0} : full[15:0];
    zero = (prod == 16'h0000);
  end

endmodule // cabx_mul
`default_nettype wire

// >>> src/cabx_exec.sv
// execution unit for word arithmetic, byte logic, multiply, indirect jumps, skips and branches
// assumes a decoder on the same clock presents one operation with its operands on start,
// and that the register file and fetch unit act on the done strobe
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RQ1: word add of 6-bit immediate to a pair, 2 cycles, flags Z C N V S.
// RQ2: word subtract of 6-bit immediate, 2 cycles, Z C N V S, half carry kept.
// RQ3: and with immediate, one cycle, only Z N V S change.
// RQ4: or with immediate, one cycle, result written back, Z N V S change.
// RQ5: set bits ors a mask in, one cycle, Z N V S change.
// RQ6: clear bits ands with inverted mask, one cycle, Z N V S change.
// RQ7: test ands a register with itself, one cycle, Z N V S change.
// RQ8: signed by unsigned multiply to lowest pair, 2 cycles, Z and C.
// RQ9: fractional multiplies shift product left once, 2 cycles, Z and C.
// RQ10: indirect jump loads pointer into pc low bits, clears top, 2 cycles.
// RQ11: indirect call loads pointer into pc, clears top, 2 or 3 cycles.
// RQ12: compare-skip on equal registers adds 2 or 3 to pc, 1 to 3 cycles.
// RQ13: register bit skips test one bit clear or set, 1 to 3 cycles.
// RQ14: io bit skips test one io bit clear or set, 1 to 3 cycles.
// RQ15: generic branch tests one status bit, pc plus offset plus one.
// RQ16: signed branches use negative xor overflow, zero or one.
// RQ17: unsigned branches use carry clear or set, 1 or 2 cycles.
// RQ18: half-carry branches jump on half carry set or clear.
// RQ19: transfer-bit branches jump on transfer flag set or clear, flags kept.
// RQ20: unlisted flags keep value; untaken branches take one cycle.
module cabx_exec
  import cabx_pkg::*;
#(
  parameter int unsigned PC_W = cabx_pkg::PC_WIDTH
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire cabx_pkg::cabx_op_t op,
  input wire logic [15:0] opnd_d,
  input wire logic [7:0] opnd_r,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  input wire logic io_bit,
  input wire logic [cabx_pkg::PTR_WIDTH-1:0] ptr_z,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [cabx_pkg::OFFSET_WIDTH-1:0] rel_off,
  input wire logic next_two_word,
  input wire logic flag_load,
  input wire logic [7:0] flag_load_value,
  output logic busy,
  output logic done,
  output logic [15:0] result,
  output logic wr_rd,
  output logic wr_low_pair,
  output logic [PC_W-1:0] pc_out,
  output logic push_ret,
  output logic [PC_W-1:0] ret_addr,
  output logic [7:0] status_flags_register
);

  // long program counters need the extra call cycle for the third return byte
  localparam logic [1:0] CALL_CYC = (PC_W > SHORT_CALL_PC_WIDTH) ? CYC_THREE : CYC_TWO;

  cabx_state_t state, next_state;
  logic [1:0] cnt, next_cnt;
  logic next_busy, next_done, next_wr_rd, next_wr_low_pair, next_push_ret;
  logic [15:0] next_result;
  logic [PC_W-1:0] next_pc_out, next_ret_addr;
  logic [7:0] next_flags;
  logic pend_rd, pend_pair, pend_push;
  logic next_pend_rd, next_pend_pair, next_pend_push;

  // per-operation decode outputs
  logic [15:0] op_res;
  logic [7:0] op_flags;
  logic [PC_W-1:0] op_pc;
  logic [1:0] op_cyc;
  logic op_rd, op_pair, op_push;

  logic accept;
  logic [7:0] lu_k, lu_res;
  cabx_logic_t lu_mode;
  logic lu_zero, lu_neg;
  logic mu_as, mu_bs, mu_frac, mu_carry, mu_zero;
  logic [15:0] mu_prod;
  logic [15:0] word_k, word_sum, word_dif;
  logic [PC_W-1:0] pc_next, pc_skip1, pc_skip2, pc_rel, pc_ptr;
  logic skip_hit, br_hit, is_skip, is_branch;

  assign accept = start && (state == ST_IDLE);

  cabx_logic u_logic (
    .a(opnd_d[7:0]),
    .k(lu_k),
    .mode(lu_mode),
    .res(lu_res),
    .zero(lu_zero),
    .neg(lu_neg)
  );

  cabx_mul u_mul (
    .a(opnd_d[7:0]),
    .b(opnd_r),
    .a_signed(mu_as),
    .b_signed(mu_bs),
    .frac(mu_frac),
    .prod(mu_prod),
    .carry(mu_carry),
    .zero(mu_zero)
  );

  // operand steering for the two helper units
  always_comb
  begin
    lu_k = imm;
    lu_mode = LOGIC_AND;
    case (op)
      OP_LOGICAL_OR_WITH_IMMEDIATE, OP_SET_BITS_IN_REGISTER: lu_mode = LOGIC_OR; // see RQ4 RQ5
      OP_CLEAR_BITS_IN_REGISTER: lu_mode = LOGIC_AND_NOT; // see RQ6
      OP_TEST_ZERO_OR_MINUS: lu_k = opnd_d[7:0]; // see RQ7
      default: lu_mode = LOGIC_AND;
    endcase
    mu_as = (op != OP_MULTIPLY_UNSIGNED) && (op != OP_FRACTIONAL_MULTIPLY_UNSIGNED);
    mu_bs = (op == OP_MULTIPLY_SIGNED) || (op == OP_FRACTIONAL_MULTIPLY_SIGNED);
    mu_frac = (op == OP_FRACTIONAL_MULTIPLY_UNSIGNED) || (op == OP_FRACTIONAL_MULTIPLY_SIGNED)
      || (op == OP_FRACTIONAL_MULTIPLY_MIXED); // see RQ9
  end

  // address arithmetic; the offset is sign-extended so backward branches wrap correctly
  always_comb
  begin
    word_k = {{(16-IMM_WORD_WIDTH){1'b0}}, imm[IMM_WORD_WIDTH-1:0]};
    word_sum = opnd_d + word_k;
    word_dif = opnd_d - word_k;
    pc_next = pc_in + PC_W'(PC_STEP_NEXT);
    pc_skip1 = pc_in + PC_W'(PC_STEP_SKIP_ONE);
    pc_skip2 = pc_in + PC_W'(PC_STEP_SKIP_TWO);
    pc_rel = pc_next + {{(PC_W-OFFSET_WIDTH){rel_off[OFFSET_WIDTH-1]}}, rel_off}; // see RQ15
    pc_ptr = {{(PC_W-PTR_WIDTH){1'b0}}, ptr_z}; // see RQ10 RQ11
  end

  // skip and branch conditions
  always_comb
  begin
    is_skip = 1'b1;
    skip_hit = 1'b0;
    case (op)
      OP_COMPARE_SKIP_IF_EQUAL: skip_hit = (opnd_d[7:0] == opnd_r); // see RQ12
      OP_SKIP_IF_REG_BIT_CLEAR: skip_hit = !opnd_r[bit_sel]; // see RQ13
      OP_SKIP_IF_REG_BIT_SET: skip_hit = opnd_r[bit_sel]; // see RQ13
      OP_SKIP_IF_IO_BIT_CLEAR: skip_hit = !io_bit; // see RQ14
      OP_SKIP_IF_IO_BIT_SET: skip_hit = io_bit; // see RQ14
      default: is_skip = 1'b0;
    endcase
    is_branch = 1'b1;
    br_hit = 1'b0;
    case (op)
      OP_BRANCH_ON_FLAG_SET: br_hit = status_flags_register[bit_sel]; // see RQ15
      OP_BRANCH_ON_FLAG_CLEAR: br_hit = !status_flags_register[bit_sel]; // see RQ15
      OP_BRANCH_GREATER_EQUAL_SIGNED:
        br_hit = !(status_flags_register[FLAG_N] ^ status_flags_register[FLAG_V]); // see RQ16
      OP_BRANCH_LESS_SIGNED:
        br_hit = status_flags_register[FLAG_N] ^ status_flags_register[FLAG_V]; // see RQ16
      OP_BRANCH_SAME_OR_HIGHER: br_hit = !status_flags_register[FLAG_C]; // see RQ17
      OP_BRANCH_LOWER_UNSIGNED: br_hit = status_flags_register[FLAG_C]; // see RQ17
      OP_BRANCH_HALF_CARRY_SET: br_hit = status_flags_register[FLAG_H]; // see RQ18
      OP_BRANCH_HALF_CARRY_CLEAR: br_hit = !status_flags_register[FLAG_H]; // see RQ18
      OP_BRANCH_TRANSFER_BIT_SET: br_hit = status_flags_register[FLAG_T]; // see RQ19
      OP_BRANCH_TRANSFER_BIT_CLEAR: br_hit = !status_flags_register[FLAG_T]; // see RQ19
      default: is_branch = 1'b0;
    endcase
  end

  // per-operation result, flags, next pc and cycle count; flags start from the old value
  always_comb
  begin
    op_res = result;
    op_flags = status_flags_register; // see RQ20
    op_pc = pc_next;
    op_cyc = CYC_ONE;
    op_rd = 1'b0;
    op_pair = 1'b0;
    op_push = 1'b0;
    case (op)
      OP_ADD_IMMEDIATE_TO_WORD:
      begin
        op_res = word_sum; // see RQ1
        op_flags[FLAG_V] = !opnd_d[15] && word_sum[15];
        op_flags[FLAG_C] = opnd_d[15] && !word_sum[15];
        op_cyc = CYC_TWO;
        op_rd = 1'b1;
      end
      OP_SUBTRACT_IMMEDIATE_FROM_WORD:
      begin
        op_res = word_dif; // see RQ2
        op_flags[FLAG_V] = opnd_d[15] && !word_dif[15];
        op_flags[FLAG_C] = word_dif[15] && !opnd_d[15];
        op_cyc = CYC_TWO;
        op_rd = 1'b1;
      end
      OP_AND_WITH_IMMEDIATE, OP_LOGICAL_OR_WITH_IMMEDIATE, OP_SET_BITS_IN_REGISTER,
      OP_CLEAR_BITS_IN_REGISTER, OP_TEST_ZERO_OR_MINUS:
      begin
        op_res = {opnd_d[15:8], lu_res};
        op_flags[FLAG_Z] = lu_zero; // see RQ3 RQ4 RQ5 RQ6 RQ7
        op_flags[FLAG_N] = lu_neg;
        op_flags[FLAG_V] = 1'b0;
        op_flags[FLAG_S] = lu_neg;
        // the test form only sets flags; the register keeps its value anyway
        op_rd = (op != OP_TEST_ZERO_OR_MINUS);
      end
      OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED, OP_MULTIPLY_SIGNED_BY_UNSIGNED,
      OP_FRACTIONAL_MULTIPLY_UNSIGNED, OP_FRACTIONAL_MULTIPLY_SIGNED,
      OP_FRACTIONAL_MULTIPLY_MIXED:
      begin
        op_res = mu_prod; // see RQ8 RQ9
        op_flags[FLAG_Z] = mu_zero;
        op_flags[FLAG_C] = mu_carry;
        op_cyc = CYC_TWO;
        op_pair = 1'b1;
      end
      OP_INDIRECT_JUMP:
      begin
        op_pc = pc_ptr; // see RQ10
        op_cyc = CYC_TWO;
      end
      OP_INDIRECT_CALL:
      begin
        op_pc = pc_ptr; // see RQ11
        op_cyc = CALL_CYC;
        op_push = 1'b1;
      end
      default:
      begin
        if (is_skip && skip_hit)
        begin
          // skipping a two-word instruction costs the extra fetch
          op_pc = next_two_word ? pc_skip2 : pc_skip1; // see RQ12 RQ13 RQ14
          op_cyc = next_two_word ? CYC_THREE : CYC_TWO;
        end
        else if (is_branch && br_hit)
        begin
          op_pc = pc_rel; // see RQ15
          op_cyc = CYC_TWO;
        end
      end
    endcase
    // only the word forms rebuild sign here; multiplies, jumps and branches leave it alone
    if (op == OP_ADD_IMMEDIATE_TO_WORD || op == OP_SUBTRACT_IMMEDIATE_FROM_WORD)
    begin
      op_flags[FLAG_Z] = (op_res == 16'h0000); // see RQ1 RQ2
      op_flags[FLAG_N] = op_res[15];
      op_flags[FLAG_S] = op_res[15] ^ op_flags[FLAG_V];
    end
  end

  // sequencer: results load at accept, done and write strobes fire after the cycle count
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    next_wr_rd = 1'b0;
    next_wr_low_pair = 1'b0;
    next_push_ret = 1'b0;
    next_result = result;
    next_pc_out = pc_out;
    next_ret_addr = ret_addr;
    next_flags = status_flags_register;
    next_pend_rd = pend_rd;
    next_pend_pair = pend_pair;
    next_pend_push = pend_push;
    if (accept)
    begin
      next_result = op_res;
      next_pc_out = op_pc;
      next_ret_addr = pc_next;
      next_flags = op_flags;
      if (op_cyc == CYC_ONE)
      begin
        next_done = 1'b1; // see RQ20
        next_wr_rd = op_rd;
        next_wr_low_pair = op_pair;
        next_push_ret = op_push;
      end
      else
      begin
        next_state = ST_RUN;
        next_busy = 1'b1;
        next_cnt = op_cyc - CYC_TWO;
        next_pend_rd = op_rd;
        next_pend_pair = op_pair;
        next_pend_push = op_push;
      end
    end
    else if (state == ST_RUN)
    begin
      if (cnt == 2'h0)
      begin
        next_state = ST_IDLE;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_wr_rd = pend_rd;
        next_wr_low_pair = pend_pair;
        next_push_ret = pend_push;
      end
      else
      begin
        next_cnt = cnt - 2'h1;
      end
    end
    else if (flag_load)
    begin
      // flag writes from the rest of the core only land between operations
      next_flags = flag_load_value;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      cnt <= 2'h0;
      busy <= 1'b0;
      done <= 1'b0;
      wr_rd <= 1'b0;
      wr_low_pair <= 1'b0;
      push_ret <= 1'b0;
      result <= 16'h0000;
      pc_out <= '0;
      ret_addr <= '0;
      status_flags_register <= FLAGS_RESET;
      pend_rd <= 1'b0;
      pend_pair <= 1'b0;
      pend_push <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
      wr_rd <= next_wr_rd;
      wr_low_pair <= next_wr_low_pair;
      push_ret <= next_push_ret;
      result <= next_result;
      pc_out <= next_pc_out;
      ret_addr <= next_ret_addr;
      status_flags_register <= next_flags;
      pend_rd <= next_pend_rd;
      pend_pair <= next_pend_pair;
      pend_push <= next_pend_push;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_word_add;
    accept && op == OP_ADD_IMMEDIATE_TO_WORD |=> !done ##1 done && wr_rd
      && result == $past(opnd_d, 2) + {10'h000, $past(imm[5:0], 2)};
  endproperty
  a_word_add: assert property (p_word_add) else $error("word add wrong"); // see RQ1
  property p_word_sub_h;
    accept && op == OP_SUBTRACT_IMMEDIATE_FROM_WORD |=> ##1 done
      && status_flags_register[FLAG_H] == $past(status_flags_register[FLAG_H], 2);
  endproperty
  a_word_sub_h: assert property (p_word_sub_h) else $error("word sub timing or h"); // see RQ2
  property p_and_with_immediate;
    accept && op == OP_AND_WITH_IMMEDIATE |=> done && wr_rd
      && result[7:0] == ($past(opnd_d[7:0]) & $past(imm)) && !status_flags_register[FLAG_V]
      && status_flags_register[FLAG_C] == $past(status_flags_register[FLAG_C]);
  endproperty
  a_and_with_immediate: assert property (p_and_with_immediate) else $error("and immediate wrong"); // see RQ3
  property p_clear_bits;
    accept && op == OP_CLEAR_BITS_IN_REGISTER |=> done
      && result[7:0] == ($past(opnd_d[7:0]) & ~$past(imm));
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear bits wrong"); // see RQ6
  property p_multiply_signed_by_unsigned;
    accept && op == OP_MULTIPLY_SIGNED_BY_UNSIGNED |=> !done ##1 done && wr_low_pair
      && result == 16'($signed($past(opnd_d[7:0], 2)) * $signed({1'b0, $past(opnd_r, 2)}));
  endproperty
  a_multiply_signed_by_unsigned: assert property (p_multiply_signed_by_unsigned) else $error("mixed multiply wrong"); // see RQ8
  property p_indirect_jump;
    accept && op == OP_INDIRECT_JUMP |=> ##1 done && pc_out == PC_W'($past(ptr_z, 2));
  endproperty
  a_indirect_jump: assert property (p_indirect_jump) else $error("indirect jump wrong"); // see RQ10
  property p_skip_two_word;
    accept && op == OP_COMPARE_SKIP_IF_EQUAL && opnd_d[7:0] == opnd_r && next_two_word
      |=> !done [*2] ##1 done && pc_out == $past(pc_in, 3) + PC_W'(PC_STEP_SKIP_TWO);
  endproperty
  a_skip_two_word: assert property (p_skip_two_word) else $error("skip wrong"); // see RQ12
  property p_branch_greater_equal_signed_untaken;
    accept && op == OP_BRANCH_GREATER_EQUAL_SIGNED
      && (status_flags_register[FLAG_N] ^ status_flags_register[FLAG_V])
      |=> done && pc_out == $past(pc_in) + PC_W'(PC_STEP_NEXT)
      && status_flags_register == $past(status_flags_register);
  endproperty
  a_branch_greater_equal_signed_untaken: assert property (p_branch_greater_equal_signed_untaken) else $error("untaken branch"); // see RQ16 RQ20
  property p_branch_lower_unsigned_taken;
    accept && op == OP_BRANCH_LOWER_UNSIGNED && status_flags_register[FLAG_C]
      |=> !done ##1 done && status_flags_register == $past(status_flags_register, 2)
      && pc_out == $past(pc_in, 2) + PC_W'(PC_STEP_NEXT) + PC_W'($signed($past(rel_off, 2)));
  endproperty
  a_branch_lower_unsigned_taken: assert property (p_branch_lower_unsigned_taken) else $error("taken branch wrong"); // see RQ17 RQ20

  c_indirect_call: cover property (accept && op == OP_INDIRECT_CALL ##[2:3] push_ret);
  c_branch_transfer_bit_set: cover property (accept && op == OP_BRANCH_TRANSFER_BIT_SET && br_hit ##2 done);
  c_fmul: cover property (accept && op == OP_FRACTIONAL_MULTIPLY_MIXED ##2 wr_low_pair);

endmodule // cabx_exec
`default_nettype wire

// >>> dv/cabx_regs_model.sv
// register file and stack stand-in fed by the block's write strobes
// assumes strobes last one cycle and arrive together with done
`timescale 1ns/100ps
`default_nettype none
module cabx_regs_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic done,
  input wire logic wr_rd,
  input wire logic wr_low_pair,
  input wire logic push_ret,
  input wire logic [15:0] result,
  input wire logic [21:0] ret_addr,
  output logic [15:0] pair_d,
  output logic [15:0] pair_low,
  output logic [21:0] stack_top
);
  // take writes only at the done edge, as a real register file would
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pair_d <= 16'h0000;
      pair_low <= 16'h0000;
      stack_top <= 22'h000000;
    end
    else if (done)
    begin
      if (wr_rd)
        pair_d <= result;
      if (wr_low_pair)
        pair_low <= result;
      if (push_ret)
        stack_top <= ret_addr;
    end
  end
endmodule // cabx_regs_model
`default_nettype wire

// >>> dv/cpu_alu_and_branch_execution_tb.sv
// self-checking bench for the execution unit, one task per scenario
// assumes the default pc width; inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module cpu_alu_and_branch_execution_tb;
  import cabx_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  cabx_op_t op = OP_TEST_ZERO_OR_MINUS;
  logic [15:0] opnd_d = 16'h0000;
  logic [7:0] opnd_r = 8'h00;
  logic [7:0] imm = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic io_bit = 1'b0;
  logic [15:0] ptr_z = 16'h0000;
  logic [21:0] pc_in = 22'h000000;
  logic [6:0] rel_off = 7'h00;
  logic next_two_word = 1'b0;
  logic flag_load = 1'b0;
  logic [7:0] flag_load_value = 8'h00;
  logic busy, done, wr_rd, wr_low_pair, push_ret, seen_wr, seen_low, seen_push;
  logic [15:0] result, pair_d, pair_low;
  logic [21:0] pc_out, ret_addr, stack_top;
  logic [7:0] flags;
  int fail_count = 0;
  int checks = 0;
  // branch table; taken bits hold for flags 8'h41 and invert for 8'hA6
  cabx_op_t br_ops [10] = '{OP_BRANCH_ON_FLAG_SET, OP_BRANCH_ON_FLAG_CLEAR,
    OP_BRANCH_GREATER_EQUAL_SIGNED, OP_BRANCH_LESS_SIGNED, OP_BRANCH_SAME_OR_HIGHER,
    OP_BRANCH_LOWER_UNSIGNED, OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR,
    OP_BRANCH_TRANSFER_BIT_SET, OP_BRANCH_TRANSFER_BIT_CLEAR};
  logic [9:0] br_taken = 10'b0110100101;
  // byte logic table: operation, operand, mask, expected low byte
  cabx_op_t lg_op [5] = '{OP_AND_WITH_IMMEDIATE, OP_LOGICAL_OR_WITH_IMMEDIATE,
    OP_SET_BITS_IN_REGISTER, OP_CLEAR_BITS_IN_REGISTER, OP_TEST_ZERO_OR_MINUS};
  logic [7:0] lg_d [5] = '{8'h0F, 8'h01, 8'h00, 8'hFF, 8'h00};
  logic [7:0] lg_k [5] = '{8'hF0, 8'h80, 8'h00, 8'h0F, 8'h00};
  logic [7:0] lg_res [5] = '{8'h00, 8'h81, 8'h00, 8'hF0, 8'h00};

  // free-running core clock, 8 ns
  always #4 clk = ~clk;

  cabx_exec dut_u (
    .clk(clk), .rst_b(rst_b), .start(start), .op(op), .opnd_d(opnd_d),
    .opnd_r(opnd_r), .imm(imm), .bit_sel(bit_sel), .io_bit(io_bit), .ptr_z(ptr_z),
    .pc_in(pc_in), .rel_off(rel_off), .next_two_word(next_two_word),
    .flag_load(flag_load), .flag_load_value(flag_load_value), .busy(busy),
    .done(done), .result(result), .wr_rd(wr_rd), .wr_low_pair(wr_low_pair),
    .pc_out(pc_out), .push_ret(push_ret), .ret_addr(ret_addr),
    .status_flags_register(flags)
  );

  cabx_regs_model model_u (
    .clk(clk), .rst_b(rst_b), .done(done), .wr_rd(wr_rd), .wr_low_pair(wr_low_pair),
    .push_ret(push_ret), .result(result), .ret_addr(ret_addr), .pair_d(pair_d),
    .pair_low(pair_low), .stack_top(stack_top)
  );

  task automatic stop_test();
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      checks++;
      if (got !== exp)
      begin
        fail_count++;
        $display("unexpected %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // issue one op, count cycles to done with a bound, keep the strobes of the done cycle
  task automatic go(input cabx_op_t o, input int ncyc);
    int n;
    begin
      @(negedge clk); // let an edge pass so start never drops and rises in one step
      op = o;
      start = 1'b1;
      n = 1;
      @(negedge clk);
      start = 1'b0;
      while (done !== 1'b1 && n < 6)
      begin
        cmp("busy", 32'h1, {31'h0, busy});
        @(negedge clk);
        n++;
      end
      if (done !== 1'b1)
      begin
        fail_count++;
        stop_test();
      end
      seen_wr = wr_rd;
      seen_low = wr_low_pair;
      seen_push = push_ret;
      cmp("cycles", ncyc, n);
    end
  endtask

  task automatic step(input cabx_op_t o, input int ncyc, input logic [21:0] exp_pc);
    begin
      go(o, ncyc);
      cmp("next pc", {10'h000, exp_pc}, {10'h000, pc_out});
    end
  endtask

  task automatic load_flags(input logic [7:0] v);
    begin
      flag_load = 1'b1;
      flag_load_value = v;
      @(negedge clk);
      flag_load = 1'b0;
    end
  endtask

  task automatic t_word();
    begin
      load_flags(8'hFF);
      opnd_d = 16'hFFFF;
      imm = 8'hC1;
      go(OP_ADD_IMMEDIATE_TO_WORD, 2);
      cmp("add sum", 32'h0000, result);
      cmp("add flags", 32'hE3, flags);
      @(negedge clk);
      cmp("pair written", 32'h0000, pair_d);
      opnd_d = 16'h0000;
      imm = 8'h01;
      go(OP_SUBTRACT_IMMEDIATE_FROM_WORD, 2);
      cmp("sub diff", 32'hFFFF, result);
      cmp("sub flags", 32'hF5, flags);
      @(negedge clk);
      cmp("pair sub", 32'hFFFF, pair_d);
    end
  endtask

  // one-cycle byte ops in turn, one idle cycle apart; carry and upper flags must survive
  task automatic t_logic();
    begin
      for (int i = 0; i < 5; i++)
      begin
        opnd_d = {8'hA5, lg_d[i]};
        imm = lg_k[i];
        go(lg_op[i], 1);
        cmp("logic res", {16'h0000, 8'hA5, lg_res[i]}, result);
        cmp("logic flags", (i % 2) ? 32'hF5 : 32'hE3, flags);
        cmp("logic write", (i != 4), seen_wr);
      end
    end
  endtask

  task automatic t_mul();
    begin
      opnd_d = 16'h00FF;
      opnd_r = 8'h02;
      go(OP_MULTIPLY_SIGNED_BY_UNSIGNED, 2);
      cmp("mul prod", 32'hFFFE, result);
      cmp("mul flags", 32'hE1, flags);
      cmp("mul low pair", 32'h1, seen_low);
      @(negedge clk);
      cmp("low pair", 32'hFFFE, pair_low);
      opnd_d = 16'h0040;
      go(OP_FRACTIONAL_MULTIPLY_MIXED, 2);
      cmp("fmul prod", 32'h0100, result);
      cmp("fmul flags", 32'hE0, flags);
      opnd_d = 16'h00FF;
      opnd_r = 8'hFE;
      go(OP_FRACTIONAL_MULTIPLY_UNSIGNED, 2);
      cmp("fmul unsigned", 32'hFA04, result);
      cmp("fmul carry", 32'hE1, flags);
      go(OP_FRACTIONAL_MULTIPLY_SIGNED, 2);
      cmp("fmul signed", 32'h0004, result);
      cmp("fmul signed flags", 32'hE0, flags);
    end
  endtask

  task automatic t_jumps();
    begin
      ptr_z = 16'h1234;
      pc_in = 22'h3F0000;
      step(OP_INDIRECT_JUMP, 2, 22'h001234);
      step(OP_INDIRECT_CALL, 3, 22'h001234);
      cmp("push", 32'h1, seen_push);
      @(negedge clk);
      cmp("stack", 32'h3F0001, stack_top);
      cmp("jump flags", 32'hE0, flags);
    end
  endtask

  task automatic t_skips();
    begin
      pc_in = 22'h000100;
      opnd_d = 16'h0033;
      opnd_r = 8'h33;
      step(OP_COMPARE_SKIP_IF_EQUAL, 2, 22'h000102);
      next_two_word = 1'b1;
      step(OP_COMPARE_SKIP_IF_EQUAL, 3, 22'h000103);
      opnd_r = 8'h34;
      step(OP_COMPARE_SKIP_IF_EQUAL, 1, 22'h000101);
      opnd_r = 8'h08;
      bit_sel = 3'h3;
      next_two_word = 1'b0;
      step(OP_SKIP_IF_REG_BIT_SET, 2, 22'h000102);
      step(OP_SKIP_IF_REG_BIT_CLEAR, 1, 22'h000101);
      next_two_word = 1'b1;
      step(OP_SKIP_IF_IO_BIT_CLEAR, 3, 22'h000103);
      step(OP_SKIP_IF_IO_BIT_SET, 1, 22'h000101);
      cmp("skip flags", 32'hE0, flags);
    end
  endtask

  // every branch under two flag patterns that flip each condition
  task automatic t_branches();
    logic tk;
    begin
      pc_in = 22'h000100;
      rel_off = 7'h7E;
      bit_sel = 3'h0;
      for (int v = 0; v < 2; v++)
      begin
        load_flags(v ? 8'hA6 : 8'h41);
        for (int i = 0; i < 10; i++)
        begin
          tk = br_taken[i] ^ v[0];
          step(br_ops[i], tk ? 2 : 1, tk ? 22'h0000FF : 22'h000101);
          cmp("branch flags", v ? 32'hA6 : 32'h41, flags);
        end
      end
    end
  endtask

  // main sequence: reset, then each scenario in turn
  initial
  begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    cmp("reset flags", FLAGS_RESET, flags);
    t_word();
    t_logic();
    t_mul();
    t_jumps();
    t_skips();
    t_branches();
    stop_test();
  end
endmodule // cpu_alu_and_branch_execution_tb
`default_nettype wire
